// ### src/syt_pkg.sv
// What this block does
// - Nine registers as consecutive 32-bit words from base 0xE000F000, offsets 0x00 to 0x20.
// - The 64-bit count decrements; reaching zero sets the zero-reached flag.
// - Software reads and writes the count as low and high 32-bit words.
// - The 64-bit reload value is held as low and high read-write words.
// - Writing 1 to control bit 8 copies the whole reload value into the count.
// - Control bit 2 picks the bus clock (1) or bus clock divided by eight (0).
// - Control bit 1 enables the counter interrupt; at 0 reaching zero leaves tick_irq low, but irq still follows the event enables.
// - Control bit 0 enables counting; at 0 the count holds its value.
// - Flag bit 1 is the zero-reached flag: writing 0 clears, writing 1 does nothing.
// - Flag bit 0 set to 1 raises a software interrupt request at once.
// - The software request stays up, so it repeats until the handler clears the bit.
// - Every register resets to zero: stopped, no interrupts, divided clock, zero values.
package syt_pkg;

    // Bus placement and register offsets.
    localparam logic [31:0] SYT_BASE_ADDR   = 32'hE000_F000;
    localparam logic [7:0]  SYT_OFF_CONTROL = 8'h00;
    localparam logic [7:0]  SYT_OFF_CNT_LO  = 8'h04;
    localparam logic [7:0]  SYT_OFF_CNT_HI  = 8'h08;
    localparam logic [7:0]  SYT_OFF_RLD_LO  = 8'h0C;
    localparam logic [7:0]  SYT_OFF_RLD_HI  = 8'h10;
    localparam logic [7:0]  SYT_OFF_FLAGS   = 8'h14;
    localparam logic [7:0]  SYT_OFF_EV_STAT = 8'h18;
    localparam logic [7:0]  SYT_OFF_EV_EN   = 8'h1C;
    localparam logic [7:0]  SYT_OFF_EV_CLR  = 8'h20;

    // Control register bit positions.
    localparam int SYT_RUN_BIT    = 0;
    localparam int SYT_IRQEN_BIT  = 1;
    localparam int SYT_TBSEL_BIT  = 2;
    localparam int SYT_RELOAD_BIT = 8;

    // Flag register bit positions.
    localparam int SYT_SOFT_BIT = 0;
    localparam int SYT_ZERO_BIT = 1;

    // Event status bit positions.
    localparam int SYT_EV_ZERO = 0;
    localparam int SYT_EV_SOFT = 1;

    // Reset values and time base.
    localparam logic [31:0] SYT_RESET_WORD = 32'h0000_0000;
    localparam logic [2:0]  SYT_DIV_LAST   = 3'h7;

    // Bus responses.
    localparam logic [1:0] SYT_RESP_OKAY   = 2'h0;
    localparam logic [1:0] SYT_RESP_SLVERR = 2'h2;

endpackage : syt_pkg

// ### src/syt_system_tick.sv
`timescale 1ns/10ps
`default_nettype none

module syt_system_tick
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             tick_irq,
    output logic             soft_irq,
    output logic             irq
);

    // Complete state of the block.
    // Bus holding registers come first, then the counter, then the flags.
    // Everything here is cleared by one synchronous reset, so no field can start unknown.
    typedef struct packed {
        logic        aw_v;
        logic [31:0] aw_a;
        logic        w_v;
        logic [31:0] w_d;
        logic [3:0]  w_s;
        logic        b_v;
        logic [1:0]  b_r;
        logic        r_v;
        logic [31:0] r_d;
        logic [1:0]  r_r;
        logic        run;
        logic        irq_en;
        logic        tb_sel;
        logic [2:0]  div;
        logic [63:0] cnt;
        logic [63:0] rld;
        logic        zflag;
        logic        soft_irq_request;
        logic [1:0]  ev_st;
        logic [1:0]  ev_en;
    } syt_state_t;

    syt_state_t q;
    syt_state_t d;

    logic        wr_fire;
    logic [7:0]  wr_off;
    logic        wr_hit;
    logic        tick;
    logic [63:0] cnt_step;
    logic        cnt_wr;
    logic        zero_ev;
    logic        soft_ev;

    // Merges a write word into a register word under the byte strobes.
    function automatic logic [31:0] syt_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (st[i])
            begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : syt_merge

    // Tells whether an address falls on one of the block's words.
    function automatic logic syt_in_map(input logic [31:0] a);
        logic ok;
        ok = (a[31:8] == syt_pkg::SYT_BASE_ADDR[31:8]) && (a[1:0] == 2'h0)
             && (a[7:0] <= syt_pkg::SYT_OFF_EV_CLR);
        return ok;
    endfunction : syt_in_map

    // Handshake readies come straight from the holding state.
    assign s_axi_awready = !q.aw_v;
    assign s_axi_wready  = !q.w_v;
    assign s_axi_arready = !q.r_v;
    assign s_axi_bvalid  = q.b_v;
    assign s_axi_bresp   = q.b_r;
    assign s_axi_rvalid  = q.r_v;
    assign s_axi_rdata   = q.r_d;
    assign s_axi_rresp   = q.r_r;

    // Interrupt outputs follow the flops only.
    assign tick_irq = q.zflag && q.irq_en;
    assign soft_irq = q.soft_irq_request;
    assign irq      = |(q.ev_st & q.ev_en);

    // A write is carried out once address and data are both held and no response is pending.
    assign wr_fire = q.aw_v && q.w_v && !q.b_v;
    assign wr_off  = q.aw_a[7:0];
    assign wr_hit  = syt_in_map(q.aw_a);

    // The counter steps every cycle on the fast base, every eighth cycle on the slow one.
    assign tick     = q.run && (q.tb_sel || (q.div == syt_pkg::SYT_DIV_LAST));
    assign cnt_step = (q.cnt == 64'h0000_0000_0000_0000) ? q.rld : q.cnt - 64'h0000_0000_0000_0001;
    assign cnt_wr   = wr_fire && wr_hit && (((wr_off == syt_pkg::SYT_OFF_CNT_LO) || (wr_off == syt_pkg::SYT_OFF_CNT_HI))
                      || ((wr_off == syt_pkg::SYT_OFF_CONTROL) && q.w_s[1] && q.w_d[syt_pkg::SYT_RELOAD_BIT]));
    assign zero_ev  = tick && !cnt_wr && (cnt_step == 64'h0000_0000_0000_0000);
    assign soft_ev  = wr_fire && wr_hit && (wr_off == syt_pkg::SYT_OFF_FLAGS) && q.w_s[0]
                      && q.w_d[syt_pkg::SYT_SOFT_BIT];

    // Next-state logic: counting first, then software writes, then the bus channels.
    // The order matters: a software write to the count comes after the tick, so it wins.
    // A tick that meets such a write raises no zero flag; a count half the write leaves alone still takes the step.
    // Flags are worked out after the writes so that a hardware set beats a clear.
    always_comb
    begin
        logic [1:0] ev_clr;
        logic       zclr;
        ev_clr = 2'h0;
        zclr   = 1'b0;
        d      = q;
        d.div  = q.run ? q.div + 3'h1 : 3'h0;
        if (tick)
        begin
            d.cnt = cnt_step;
        end
        if (wr_fire)
        begin
            d.aw_v = 1'b0;
            d.w_v  = 1'b0;
            d.b_v  = 1'b1;
            d.b_r  = wr_hit ? syt_pkg::SYT_RESP_OKAY : syt_pkg::SYT_RESP_SLVERR;
            if (wr_hit)
            begin
                case (wr_off)
                    syt_pkg::SYT_OFF_CONTROL:
                    begin
                        if (q.w_s[0])
                        begin
                            d.run    = q.w_d[syt_pkg::SYT_RUN_BIT];
                            d.irq_en = q.w_d[syt_pkg::SYT_IRQEN_BIT];
                            d.tb_sel = q.w_d[syt_pkg::SYT_TBSEL_BIT];
                        end
                        if (q.w_s[1] && q.w_d[syt_pkg::SYT_RELOAD_BIT])
                        begin
                            d.cnt = q.rld;
                        end
                    end
                    syt_pkg::SYT_OFF_CNT_LO: d.cnt[31:0]  = syt_merge(q.cnt[31:0], q.w_d, q.w_s);
                    syt_pkg::SYT_OFF_CNT_HI: d.cnt[63:32] = syt_merge(q.cnt[63:32], q.w_d, q.w_s);
                    syt_pkg::SYT_OFF_RLD_LO: d.rld[31:0]  = syt_merge(q.rld[31:0], q.w_d, q.w_s);
                    syt_pkg::SYT_OFF_RLD_HI: d.rld[63:32] = syt_merge(q.rld[63:32], q.w_d, q.w_s);
                    syt_pkg::SYT_OFF_FLAGS:
                    begin
                        if (q.w_s[0])
                        begin
                            zclr   = !q.w_d[syt_pkg::SYT_ZERO_BIT];
                            d.soft_irq_request = q.w_d[syt_pkg::SYT_SOFT_BIT];
                        end
                    end
                    syt_pkg::SYT_OFF_EV_EN:
                    begin
                        if (q.w_s[0])
                        begin
                            d.ev_en = q.w_d[1:0];
                        end
                    end
                    syt_pkg::SYT_OFF_EV_CLR:
                    begin
                        if (q.w_s[0])
                        begin
                            ev_clr = q.w_d[1:0];
                        end
                    end
                    default:
                    begin
                        d.b_r = syt_pkg::SYT_RESP_OKAY;
                    end
                endcase
            end
        end
        // A hardware set in the same cycle as a clear wins.
        d.zflag = (q.zflag && !zclr) || zero_ev;
        d.ev_st[syt_pkg::SYT_EV_ZERO] = (q.ev_st[syt_pkg::SYT_EV_ZERO] && !ev_clr[syt_pkg::SYT_EV_ZERO]) || zero_ev;
        d.ev_st[syt_pkg::SYT_EV_SOFT] = (q.ev_st[syt_pkg::SYT_EV_SOFT] && !ev_clr[syt_pkg::SYT_EV_SOFT]) || soft_ev;
        // Address and data are taken in either order and held until the write is done.
        if (s_axi_awvalid && !q.aw_v)
        begin
            d.aw_v = 1'b1;
            d.aw_a = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.w_v)
        begin
            d.w_v = 1'b1;
            d.w_d = s_axi_wdata;
            d.w_s = s_axi_wstrb;
        end
        if (q.b_v && s_axi_bready)
        begin
            d.b_v = 1'b0;
        end
        // Reads answer one cycle after the address is taken.
        // The two count halves are read separately, so a running count may tear between them.
        if (q.r_v && s_axi_rready)
        begin
            d.r_v = 1'b0;
        end
        if (s_axi_arvalid && !q.r_v)
        begin
            d.r_v = 1'b1;
            d.r_r = syt_pkg::SYT_RESP_OKAY;
            d.r_d = syt_pkg::SYT_RESET_WORD;
            if (!syt_in_map(s_axi_araddr))
            begin
                d.r_r = syt_pkg::SYT_RESP_SLVERR;
            end
            else
            begin
                case (s_axi_araddr[7:0])
                    syt_pkg::SYT_OFF_CONTROL:
                    begin
                        d.r_d[syt_pkg::SYT_RUN_BIT]   = q.run;
                        d.r_d[syt_pkg::SYT_IRQEN_BIT] = q.irq_en;
                        d.r_d[syt_pkg::SYT_TBSEL_BIT] = q.tb_sel; // trigger bit reads zero
                    end
                    syt_pkg::SYT_OFF_CNT_LO:  d.r_d = q.cnt[31:0];
                    syt_pkg::SYT_OFF_CNT_HI:  d.r_d = q.cnt[63:32];
                    syt_pkg::SYT_OFF_RLD_LO:  d.r_d = q.rld[31:0];
                    syt_pkg::SYT_OFF_RLD_HI:  d.r_d = q.rld[63:32];
                    syt_pkg::SYT_OFF_FLAGS:
                    begin
                        d.r_d[syt_pkg::SYT_ZERO_BIT] = q.zflag;
                        d.r_d[syt_pkg::SYT_SOFT_BIT] = q.soft_irq_request;
                    end
                    syt_pkg::SYT_OFF_EV_STAT: d.r_d[1:0] = q.ev_st;
                    syt_pkg::SYT_OFF_EV_EN:   d.r_d[1:0] = q.ev_en;
                    default:                  d.r_d = syt_pkg::SYT_RESET_WORD;
                endcase
            end
        end
    end

    // State register with synchronous reset to all zero.
    // The reset leaves the counter stopped on the divided base with all interrupts off.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    default clocking syt_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Checks on the counter, flags and bus.
    // Every check is switched off while reset is held, except the one on the reset values.
    // A software write to the count takes over the counter, so the step checks exclude it.
    reload_copy_a: assert property (wr_fire && wr_hit && wr_off == syt_pkg::SYT_OFF_CONTROL && q.w_s[1]
        && q.w_d[syt_pkg::SYT_RELOAD_BIT] |=> q.cnt == $past(q.rld))
        else $error("Reload trigger did not copy the reload value.");
    zero_flag_a: assert property (tick && !cnt_wr && q.cnt == 64'h0000_0000_0000_0001 |=> q.zflag)
        else $error("Zero flag not set on reaching zero.");
    hold_count_a: assert property (!q.run && !cnt_wr |=> $stable(q.cnt))
        else $error("Count moved while stopped.");
    fast_base_a: assert property (q.run && q.tb_sel && !cnt_wr && q.cnt != 64'h0000_0000_0000_0000
        |=> q.cnt == $past(q.cnt) - 64'h0000_0000_0000_0001)
        else $error("Fast time base did not step each cycle.");
    slow_base_a: assert property (q.run && !q.tb_sel && !cnt_wr && q.div != syt_pkg::SYT_DIV_LAST
        |=> $stable(q.cnt))
        else $error("Slow time base stepped early.");
    tick_irq_gate_a: assert property (zero_ev ##1 !q.irq_en |-> !tick_irq)
        else $error("Counter interrupt raised while disabled.");
    tick_irq_set_a: assert property (zero_ev && q.irq_en && !wr_fire |=> tick_irq)
        else $error("Counter interrupt missing.");
    soft_req_a: assert property (soft_ev |=> soft_irq [*2] or ##1 (wr_fire && wr_off == syt_pkg::SYT_OFF_FLAGS))
        else $error("Software request not raised.");
    flag_clear_a: assert property (wr_fire && wr_hit && wr_off == syt_pkg::SYT_OFF_FLAGS && q.w_s[0]
        && !q.w_d[syt_pkg::SYT_ZERO_BIT] && !zero_ev |=> !q.zflag)
        else $error("Zero flag not cleared by writing zero.");
    rewrap_a: assert property (tick && !cnt_wr && q.cnt == 64'h0000_0000_0000_0000 |=> q.cnt == $past(q.rld))
        else $error("Count did not restart from reload.");
    reset_zero_a: assert property (disable iff (1'b0) !aresetn |=> q.cnt == 64'h0000_0000_0000_0000
        && !q.run && !q.irq_en && !q.tb_sel && !q.zflag && !q.soft_irq_request && q.rld == 64'h0000_0000_0000_0000)
        else $error("Registers not zero after reset.");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("Read not answered in one cycle.");

    // The divider restarts from zero whenever counting stops.
    stop_div_a: assert property (!q.run |=> q.div == 3'h0)
        else $error("Divider not held at zero while stopped.");

    // On the slow base the eighth cycle steps the count by one.
    slow_step_a: assert property (q.run && !q.tb_sel && q.div == syt_pkg::SYT_DIV_LAST && !cnt_wr
        && q.cnt != 64'h0000_0000_0000_0000 |=> q.cnt == $past(q.cnt) - 64'h0000_0000_0000_0001)
        else $error("Slow time base missed its step.");

    // With its enable off the counter interrupt stays low.
    irq_gate_off_a: assert property (!q.irq_en |-> !tick_irq)
        else $error("Counter interrupt high while disabled.");

    // Writing zero to the software bit drops the request.
    soft_clear_a: assert property (wr_fire && wr_hit && wr_off == syt_pkg::SYT_OFF_FLAGS && q.w_s[0]
        && !q.w_d[syt_pkg::SYT_SOFT_BIT] |=> !soft_irq)
        else $error("Software request not dropped.");

    // The software request stays up until software writes the flag word.
    soft_stay_a: assert property (soft_irq && !(wr_fire && wr_off == syt_pkg::SYT_OFF_FLAGS) |=> soft_irq)
        else $error("Software request fell on its own.");

    // Writing one to the zero flag leaves it set.
    flag_keep_a: assert property (wr_fire && wr_hit && wr_off == syt_pkg::SYT_OFF_FLAGS
        && q.w_d[syt_pkg::SYT_ZERO_BIT] && q.zflag |=> q.zflag)
        else $error("Zero flag lost on writing one.");

    // A full-word write to the low count half lands as written.
    cnt_low_wr_a: assert property (wr_fire && wr_hit && wr_off == syt_pkg::SYT_OFF_CNT_LO && q.w_s == 4'hF
        |=> q.cnt[31:0] == $past(q.w_d))
        else $error("Low count half not written.");

    // A full-word write to the high count half lands as written.
    cnt_high_wr_a: assert property (wr_fire && wr_hit && wr_off == syt_pkg::SYT_OFF_CNT_HI && q.w_s == 4'hF
        |=> q.cnt[63:32] == $past(q.w_d))
        else $error("High count half not written.");

    // A full-word write to the low reload half lands as written.
    rld_low_wr_a: assert property (wr_fire && wr_hit && wr_off == syt_pkg::SYT_OFF_RLD_LO && q.w_s == 4'hF
        |=> q.rld[31:0] == $past(q.w_d))
        else $error("Low reload half not written.");

    // A full-word write to the high reload half lands as written.
    rld_high_wr_a: assert property (wr_fire && wr_hit && wr_off == syt_pkg::SYT_OFF_RLD_HI && q.w_s == 4'hF
        |=> q.rld[63:32] == $past(q.w_d))
        else $error("High reload half not written.");

    // Every performed write is answered in the next cycle.
    write_resp_a: assert property (wr_fire |=> s_axi_bvalid)
        else $error("Write not answered.");

    // Read data stand until the master takes them.
    resp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("Read answer changed before it was taken.");

    // The reload trigger always reads back as zero.
    trig_read_a: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr[7:0] == syt_pkg::SYT_OFF_CONTROL |=> !s_axi_rdata[syt_pkg::SYT_RELOAD_BIT])
        else $error("Reload trigger read back as one.");

    wrap_seen_c: cover property (tick && q.cnt == 64'h0000_0000_0000_0000 && q.rld != 64'h0000_0000_0000_0000);
    slow_tick_c: cover property (tick && !q.tb_sel);
    irq_seen_c:  cover property (tick_irq && irq);
    soft_seen_c: cover property (soft_ev);
    soft_drop_c: cover property (soft_irq ##1 !soft_irq);

endmodule : syt_system_tick

`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;

    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [31:0] awaddr = 32'h0000_0000;
    logic        awvalid = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0]  wstrb = 4'h0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic [31:0] araddr = 32'h0000_0000;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, tick_irq, soft_irq, irq;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata, v;
    logic [31:0] exp_r[$];
    logic [1:0]  exp_rr[$], exp_b[$];
    int          errors = 0;
    int          n_checks = 0;
    int          seed = 58407;
    int          n;

    // Free-running bus clock at 40 MHz.
    always #12.5 aclk = ~aclk;

    syt_system_tick syt_system_tick_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .tick_irq(tick_irq), .soft_irq(soft_irq), .irq(irq));

    // Comparisons of data words, response codes and levels.
    task automatic chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_w

    task automatic chk_b(input string nm, input logic [1:0] e, input logic [1:0] g);
        chk_w(nm, {30'h0000_0000, e}, {30'h0000_0000, g});
    endtask : chk_b

    task automatic chk_l(input string nm, input logic e, input logic g);
        chk_w(nm, {31'h0000_0000, e}, {31'h0000_0000, g});
    endtask : chk_l

    // Byte address of a register offset.
    function automatic logic [31:0] ad(input logic [7:0] off);
        return syt_pkg::SYT_BASE_ADDR | {24'h00_0000, off};
    endfunction : ad

    // Write cycle: address and data offered together, each released when taken.
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
        logic ah, wh, ao, wo, bh;
        ao = 1'b0;
        wo = 1'b0;
        bh = 1'b0;
        exp_b.push_back(r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (int k = 0; k < 50 && !(ao && wo); k++)
        begin
            @(negedge aclk);
            ah = awvalid && awready;
            wh = wvalid && wready;
            @(posedge aclk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            ao = ao | ah;
            wo = wo | wh;
        end
        bready <= 1'b1;
        for (int k = 0; k < 50 && !bh; k++)
        begin
            @(negedge aclk);
            bh = bvalid;
            @(posedge aclk);
        end
        bready <= 1'b0;
        chk_l("write_done", 1'b1, ao && wo && bh);
    endtask : wr

    // Read cycle; the expected word and code are noted for the monitor.
    task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
        logic ah, rh;
        ah = 1'b0;
        rh = 1'b0;
        exp_r.push_back(e);
        exp_rr.push_back(r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        for (int k = 0; k < 50 && !ah; k++)
        begin
            @(negedge aclk);
            ah = arready;
            @(posedge aclk);
        end
        arvalid <= 1'b0;
        rready <= 1'b1;
        for (int k = 0; k < 50 && !rh; k++)
        begin
            @(negedge aclk);
            rh = rvalid;
            @(posedge aclk);
        end
        rready <= 1'b0;
        chk_l("read_done", 1'b1, ah && rh);
    endtask : rd

    // Interrupt levels sampled mid-cycle, where the flops have settled.
    task automatic irqs(input logic et, input logic es, input logic ei);
        @(negedge aclk);
        chk_l("tick_irq", et, tick_irq);
        chk_l("soft_irq", es, soft_irq);
        chk_l("irq", ei, irq);
    endtask : irqs

    // Cycles until the counter interrupt rises, bounded.
    task automatic wait_tick(output int c);
        c = 0;
        @(negedge aclk);
        while (tick_irq !== 1'b1 && c < 100)
        begin
            @(negedge aclk);
            c++;
        end
    endtask : wait_tick

    task automatic end_sim;
        $display("Checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim

    // Monitor: each response seen takes the oldest note off its queue.
    always @(posedge aclk)
    begin
        if (bvalid && bready) chk_b("bresp", exp_b.pop_front(), bresp);
        if (rvalid && rready)
        begin
            chk_w("rdata", exp_r.pop_front(), rdata);
            chk_b("rresp", exp_rr.pop_front(), rresp);
        end
    end

    // Watchdog against a hung handshake.
    initial
    begin
        repeat (20000) @(posedge aclk);
        errors++;
        end_sim();
    end

    // Main sequence.
    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 9; i++) rd(ad(8'(i * 4)), 32'h0000_0000);
        irqs(1'b0, 1'b0, 1'b0);
        $display("Test reset done");
        for (int i = 1; i < 5; i++)
        begin
            v = $random(seed);
            wr(ad(8'(i * 4)), v);
            rd(ad(8'(i * 4)), v);
        end
        wr(ad(8'h24), 32'h0000_0001, syt_pkg::SYT_RESP_SLVERR);
        rd(ad(8'h24), 32'h0000_0000, syt_pkg::SYT_RESP_SLVERR);
        rd(32'hE000_E000, 32'h0000_0000, syt_pkg::SYT_RESP_SLVERR);
        v = $random(seed);
        wr(ad(syt_pkg::SYT_OFF_RLD_HI), v);
        wr(ad(syt_pkg::SYT_OFF_RLD_LO), 32'h0000_0004);
        wr(ad(syt_pkg::SYT_OFF_CONTROL), 32'h0000_0100);
        rd(ad(syt_pkg::SYT_OFF_CNT_LO), 32'h0000_0004);
        rd(ad(syt_pkg::SYT_OFF_CNT_HI), v);
        rd(ad(syt_pkg::SYT_OFF_CONTROL), 32'h0000_0000);
        wr(ad(syt_pkg::SYT_OFF_RLD_HI), 32'h0000_0000);
        wr(ad(syt_pkg::SYT_OFF_CONTROL), 32'h0000_0105);
        repeat (20) @(posedge aclk);
        irqs(1'b0, 1'b0, 1'b0);
        wr(ad(syt_pkg::SYT_OFF_CONTROL), 32'h0000_0004);
        rd(ad(syt_pkg::SYT_OFF_FLAGS), 32'h0000_0002);
        rd(ad(syt_pkg::SYT_OFF_EV_STAT), 32'h0000_0001);
        wr(ad(syt_pkg::SYT_OFF_CONTROL), 32'h0000_0006);
        irqs(1'b1, 1'b0, 1'b0);
        wr(ad(syt_pkg::SYT_OFF_FLAGS), 32'h0000_0002);
        rd(ad(syt_pkg::SYT_OFF_FLAGS), 32'h0000_0002);
        wr(ad(syt_pkg::SYT_OFF_EV_EN), 32'h0000_0001);
        irqs(1'b1, 1'b0, 1'b1);
        wr(ad(syt_pkg::SYT_OFF_EV_CLR), 32'h0000_0001);
        wr(ad(syt_pkg::SYT_OFF_FLAGS), 32'h0000_0000);
        irqs(1'b0, 1'b0, 1'b0);
        rd(ad(syt_pkg::SYT_OFF_FLAGS), 32'h0000_0000);
        $display("Test flags done");
        wr(ad(syt_pkg::SYT_OFF_CONTROL), 32'h0000_0107);
        wait_tick(n);
        chk_l("fast_time", 1'b1, n <= 12);
        wr(ad(syt_pkg::SYT_OFF_FLAGS), 32'h0000_0000);
        wait_tick(n);
        chk_l("restart_time", 1'b1, n <= 12);
        wr(ad(syt_pkg::SYT_OFF_CONTROL), 32'h0000_0002);
        wr(ad(syt_pkg::SYT_OFF_FLAGS), 32'h0000_0000);
        wr(ad(syt_pkg::SYT_OFF_CONTROL), 32'h0000_0103);
        wait_tick(n);
        chk_l("div_time", 1'b1, n >= 24 && n <= 48);
        wr(ad(syt_pkg::SYT_OFF_CONTROL), 32'h0000_0000);
        wr(ad(syt_pkg::SYT_OFF_FLAGS), 32'h0000_0000);
        wr(ad(syt_pkg::SYT_OFF_EV_CLR), 32'h0000_0003);
        $display("Test time base done");
        wr(ad(syt_pkg::SYT_OFF_FLAGS), 32'h0000_0001);
        irqs(1'b0, 1'b1, 1'b0);
        repeat (5) @(posedge aclk);
        irqs(1'b0, 1'b1, 1'b0);
        rd(ad(syt_pkg::SYT_OFF_EV_STAT), 32'h0000_0002);
        wr(ad(syt_pkg::SYT_OFF_EV_EN), 32'h0000_0002);
        wr(ad(syt_pkg::SYT_OFF_FLAGS), 32'h0000_0000);
        irqs(1'b0, 1'b0, 1'b1);
        wr(ad(syt_pkg::SYT_OFF_EV_CLR), 32'h0000_0002);
        irqs(1'b0, 1'b0, 1'b0);
        $display("Test soft request done");
        repeat (5) @(posedge aclk);
        end_sim();
    end

endmodule : tb_top

`default_nettype wire
